/* sbsf_pkg.sv */
// Constants, codes and register map of the serial boot status flags block.
// Assumes a 250 MHz system clock and an AXI4-Lite register port.
//
// Contract
// R1: Download done sets checksum match flag
// R2: Two-bit field keeps last ID check result
// R3: Refuse protected commands until ID verified
// R4: Receive timeout flag set on missing bytes
// R5: Timeout discards data, returns to command wait
// R6: Area flag always shows selected ROM area
// R7: Programmer reads status after erase or program
// R8: Read-status sends secondary after flash status
// R9: Clear-status command clears secondary status flags
// R10: Flags zero at power-on, survive reset
// R11: Timeout counts clocks, restarted per byte
package sbsf_pkg;

  // Clock and receive timeout timing
  localparam int SBSF_CLK_PS     = 4000;
  localparam int SBSF_TOUT_NS    = 100000;
  localparam int SBSF_TOUT_CYC   = (SBSF_TOUT_NS * 1000) / SBSF_CLK_PS;
  localparam int SBSF_TOUT_W     = 16;

  // Register byte offsets
  localparam logic [3:0] SBSF_OFF_STAT = 4'h0;
  localparam logic [3:0] SBSF_OFF_TOUT = 4'h4;
  localparam logic [3:0] SBSF_OFF_CTRL = 4'h8;

  // Control register fields and reset
  localparam int SBSF_CTRL_EN    = 0;
  localparam int SBSF_CTRL_CLR   = 1;
  localparam logic SBSF_EN_RST   = 1'b1;

  // Secondary status byte bit positions
  localparam int SBSF_BIT_BOOT   = 7;
  localparam int SBSF_BIT_SUM    = 4;
  localparam int SBSF_BIT_IDHI   = 3;
  localparam int SBSF_BIT_IDLO   = 2;
  localparam int SBSF_BIT_TOUT   = 1;
  localparam int SBSF_BIT_AREA   = 0;

  // ID check result codes
  localparam logic [1:0] SBSF_ID_NONE = 2'h0;
  localparam logic [1:0] SBSF_ID_BAD  = 2'h1;
  localparam logic [1:0] SBSF_ID_OK   = 2'h3;

  // Command codes
  localparam logic [7:0] SBSF_CMD_RSTAT = 8'h70;
  localparam logic [7:0] SBSF_CMD_CLR   = 8'h50;
  localparam logic [7:0] SBSF_CMD_IDCHK = 8'hf5;
  localparam logic [7:0] SBSF_CMD_VER   = 8'hfb;

  // AXI responses
  localparam logic [1:0] SBSF_RESP_OK  = 2'h0;
  localparam logic [1:0] SBSF_RESP_ERR = 2'h2;

  // Command handler states
  typedef enum logic [1:0] {
    SBSF_WAIT  = 2'b00,
    SBSF_SEND1 = 2'b01,
    SBSF_SEND2 = 2'b10,
    SBSF_RECV  = 2'b11
  } sbsf_state_t;

  // Codes other than ID check and version; the handler also lets read-status and clear-status through
  function automatic logic sbsf_is_prot(input logic [7:0] code);
    sbsf_is_prot = (code != SBSF_CMD_IDCHK) && (code != SBSF_CMD_VER);
  endfunction : sbsf_is_prot

endpackage : sbsf_pkg

/* sbsf_timer.sv */
// Inter-byte receive timeout counter.
// Assumes restart is high whenever the handler is not receiving.
`timescale 1ns/1ps
module sbsf_timer
  import sbsf_pkg::*;
#(
  parameter int W = SBSF_TOUT_W
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  // Refuse widths the counter cannot serve
  if (W < 2 || W > 32) begin : g_chk
    $error("sbsf_timer: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] cnt;   // Cycles since last byte
    logic         exp;   // Expiry pulse
  } sbsf_tmr_t;

  sbsf_tmr_t s_r;        // State
  sbsf_tmr_t s_nxt;      // Next state

  assign expired = s_r.exp;

  // Count idle cycles, pulse at the limit
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.exp = 1'b0;
    // R11: restart per byte
    if (restart)
    begin
      s_nxt.cnt = '0;
    end
    else if (s_r.cnt + 1'b1 >= limit)
    begin
      s_nxt.cnt = '0;
      s_nxt.exp = 1'b1;
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  AST_TMR_RESTART: assert property (@(posedge clk) disable iff (!rstn) // R11
    restart |=> (s_r.cnt == '0) && !expired)
    else $error("timer did not restart");

  AST_TMR_LIMIT: assert property (@(posedge clk) disable iff (!rstn) // R11
    (!restart && s_r.cnt + 1'b1 == limit) |=> expired)
    else $error("timer missed its limit");

endmodule : sbsf_timer

/* sbsf_top.sv */
// Serial programming command handler with secondary status flags.
// Assumes received bytes arrive as one-cycle pulses on rxValid, the flash
// and download logic give status and done pulses, porN is power-on only.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sbsf_top
  import sbsf_pkg::*;
#(
  parameter int TOUT_CYC = SBSF_TOUT_CYC
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        porN,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        cmdDone,
  input  wire logic [7:0]  flashStatus,
  input  wire logic        dlDone,
  input  wire logic        dlSumOk,
  input  wire logic        idDone,
  input  wire logic        idMatch,
  input  wire logic        areaSel,
  output logic             txValid,
  output logic [7:0]       txByte,
  output logic             cmdAccept,
  output logic [7:0]       cmdCode,
  output logic             cmdRefused,
  output logic             dataValid,
  output logic [7:0]       dataByte,
  output logic             discard,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Timeout must fit the counter
  if (TOUT_CYC < 1 || TOUT_CYC >= (1 << SBSF_TOUT_W)) begin : g_chk
    $error("sbsf_top: TOUT_CYC out of range");
  end

  // Handler and bus state
  typedef struct packed {
    sbsf_state_t      st;        // Handler state
    logic             txValid;   // Reply byte strobe
    logic [7:0]       txByte;    // Reply byte
    logic             accept;    // Command accepted pulse
    logic [7:0]       code;      // Last accepted code
    logic             refused;   // Command refused pulse
    logic             dValid;    // Payload byte strobe
    logic [7:0]       dByte;     // Payload byte
    logic             discard;   // Timeout discard pulse
    logic             en;        // Handler enable
    logic             swClr;     // Software flag clear pulse
    logic [SBSF_TOUT_W-1:0] tout; // Timeout limit
    logic             awready;
    logic             wready;
    logic             awHeld;    // Write address captured
    logic             wHeld;     // Write data captured
    logic [3:0]       awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sbsf_core_t;

  // Secondary status flags, power-on domain
  typedef struct packed {
    logic       boot;   // Download finished
    logic       sum;    // Checksum matched
    logic [1:0] id;     // ID check result
    logic       tout;   // Receive timeout
    logic       area;   // Selected ROM area
  } sbsf_flag_t;

  sbsf_core_t s_r;      // Core state
  sbsf_core_t s_nxt;    // Core next state
  sbsf_flag_t f_r;      // Flag state
  sbsf_flag_t f_nxt;    // Flag next state
  logic       tExp;     // Timer expiry
  logic       restart;  // Timer restart
  logic       isCmd;    // Command byte seen in wait
  logic       clrCmd;   // Clear-status command seen
  logic [7:0] secByte;  // Secondary status byte

  // Assembled secondary status byte
  assign secByte = {f_r.boot, 2'b00, f_r.sum, f_r.id, f_r.tout, f_r.area};
  assign isCmd   = (s_r.st == SBSF_WAIT) && s_r.en && rxValid;
  assign clrCmd  = isCmd && (rxByte == SBSF_CMD_CLR);
  assign restart = (s_r.st != SBSF_RECV) || rxValid;

  // Inter-byte timeout
  sbsf_timer #(.W(SBSF_TOUT_W)) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .restart (restart),
    .limit   (s_r.tout),
    .expired (tExp)
  );

  // Command handler and AXI slave
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.txValid = 1'b0;
    s_nxt.accept  = 1'b0;
    s_nxt.refused = 1'b0;
    s_nxt.dValid  = 1'b0;
    s_nxt.discard = 1'b0;
    s_nxt.swClr   = 1'b0;
    unique case (s_r.st)
      SBSF_WAIT:
      begin
        if (isCmd && rxByte == SBSF_CMD_RSTAT)
          s_nxt.st = SBSF_SEND1;
        // R3: gate on ID result
        else if (isCmd && rxByte != SBSF_CMD_CLR && sbsf_is_prot(rxByte)
                 && f_r.id != SBSF_ID_OK)
          s_nxt.refused = 1'b1;
        else if (isCmd && rxByte != SBSF_CMD_CLR)
        begin
          s_nxt.accept = 1'b1;
          s_nxt.code   = rxByte;
          s_nxt.st     = SBSF_RECV;
        end
      end
      // R8: flash status first
      SBSF_SEND1:
      begin
        s_nxt.txValid = 1'b1;
        s_nxt.txByte  = flashStatus;
        s_nxt.st      = SBSF_SEND2;
      end
      // R8: secondary byte second
      SBSF_SEND2:
      begin
        s_nxt.txValid = 1'b1;
        s_nxt.txByte  = secByte;
        s_nxt.st      = SBSF_WAIT;
      end
      SBSF_RECV:
      begin
        // R5: drop data, wait command
        if (tExp)
        begin
          s_nxt.discard = 1'b1;
          s_nxt.st      = SBSF_WAIT;
        end
        else if (cmdDone)
          s_nxt.st = SBSF_WAIT;
        else if (rxValid)
        begin
          s_nxt.dValid = 1'b1;
          s_nxt.dByte  = rxByte;
        end
      end
    endcase
    // Write address and data, either order
    if (s_axi_awvalid && s_r.awready)
    begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready)
    begin
      s_nxt.wHeld = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
    end
    // Commit write once both halves held
    if (s_r.awHeld && s_r.wHeld && !s_r.bvalid)
    begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = SBSF_RESP_OK;
      if (s_r.awAddr == SBSF_OFF_TOUT)
      begin
        if (s_r.wStrb[0])
          s_nxt.tout[7:0] = s_r.wData[7:0];
        if (s_r.wStrb[1])
          s_nxt.tout[15:8] = s_r.wData[15:8];
      end
      else if (s_r.awAddr == SBSF_OFF_CTRL)
      begin
        if (s_r.wStrb[0])
        begin
          s_nxt.en    = s_r.wData[SBSF_CTRL_EN];
          s_nxt.swClr = s_r.wData[SBSF_CTRL_CLR];
        end
      end
      else if (s_r.awAddr != SBSF_OFF_STAT)
        s_nxt.bresp = SBSF_RESP_ERR;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    s_nxt.awready = !s_nxt.awHeld && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.wHeld && !s_nxt.bvalid;
    // Read decode
    if (s_axi_arvalid && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = SBSF_RESP_OK;
      s_nxt.rdata  = '0;
      unique case (s_axi_araddr)
        SBSF_OFF_STAT: s_nxt.rdata = {14'h0000, s_r.st, flashStatus, secByte};
        SBSF_OFF_TOUT: s_nxt.rdata = {16'h0000, s_r.tout};
        SBSF_OFF_CTRL: s_nxt.rdata = {31'h00000000, s_r.en};
        default:       s_nxt.rresp = SBSF_RESP_ERR;
      endcase
    end
    else if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // Flag updates; events win over clears
  always_comb
  begin
    f_nxt = f_r;
    // R9: clear-status command
    if (clrCmd || s_r.swClr)
      f_nxt = '0;
    // R1: checksum result
    if (dlDone)
    begin
      f_nxt.boot = 1'b1;
      f_nxt.sum  = dlSumOk;
    end
    // R2: ID check result
    if (idDone)
      f_nxt.id = idMatch ? SBSF_ID_OK : SBSF_ID_BAD;
    // R4: timeout flag
    if (tExp && s_r.st == SBSF_RECV)
      f_nxt.tout = 1'b1;
    // R6: live area selection
    f_nxt.area = areaSel;
  end

  // Core register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r         <= '0;
      s_r.en      <= SBSF_EN_RST;
      s_r.tout    <= SBSF_TOUT_W'(TOUT_CYC);
      s_r.arready <= 1'b1;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // R10: flags reset by power-on only, not by rstn
  always_ff @(posedge clk or negedge porN)
  begin
    if (!porN)
      f_r <= '0;
    else
      f_r <= f_nxt;
  end

  // Outputs straight from flops
  assign txValid       = s_r.txValid;
  assign txByte        = s_r.txByte;
  assign cmdAccept     = s_r.accept;
  assign cmdCode       = s_r.code;
  assign cmdRefused    = s_r.refused;
  assign dataValid     = s_r.dValid;
  assign dataByte      = s_r.dByte;
  assign discard       = s_r.discard;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !porN);

  AST_RSTAT_PAIR: assert property ( // R8
    (isCmd && rxByte == SBSF_CMD_RSTAT)
      |=> ##1 (txValid && txByte == $past(flashStatus)) ##1 txValid ##1 !txValid)
    else $error("read-status reply not two bytes");

  AST_CLEAR: assert property ( // R9
    (clrCmd && !dlDone && !idDone) |=> (secByte[7:1] == 7'h00))
    else $error("clear-status left flags set");

  AST_SUM: assert property ( // R1
    dlDone |=> (f_r.sum == $past(dlSumOk)) && f_r.boot)
    else $error("checksum flag wrong");

  AST_ID: assert property ( // R2
    idDone |=> f_r.id == ($past(idMatch) ? SBSF_ID_OK : SBSF_ID_BAD))
    else $error("ID result field wrong");

  AST_REFUSE: assert property ( // R3
    (isCmd && sbsf_is_prot(rxByte) && rxByte != SBSF_CMD_CLR
     && rxByte != SBSF_CMD_RSTAT && f_r.id != SBSF_ID_OK)
      |=> cmdRefused && !cmdAccept && s_r.st == SBSF_WAIT)
    else $error("protected command not refused");

  AST_TOUT: assert property ( // R4
    (tExp && s_r.st == SBSF_RECV) |=> f_r.tout && discard)
    else $error("timeout not flagged");

  AST_DISCARD: assert property ( // R5
    discard |-> s_r.st == SBSF_WAIT && !dataValid)
    else $error("timeout did not return to wait");

  AST_AREA: assert property ( // R6
    ##1 1'b1 |-> f_r.area == $past(areaSel))
    else $error("area flag not tracking");

  AST_BRESP: assert property (
    (s_r.awHeld && s_r.wHeld && !s_r.bvalid) |=> s_axi_bvalid)
    else $error("write response missing");

endmodule : sbsf_top

/* sbsf_prog_model.sv */
// External programmer model on the serial command port.
// Assumes one reply byte per txValid pulse, replies within two cycles.
`timescale 1ns/1ps
module sbsf_prog_model
  import sbsf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  output logic            rxValid,
  output logic [7:0]      rxByte
);
  logic [7:0] got[$];  // Reply bytes seen

  // Idle line at power-up
  initial
  begin
    rxValid = 1'b0;
    rxByte  = 8'h00;
  end

  // Collect reply bytes
  always @(posedge clk)
    if (txValid === 1'b1)
      got.push_back(txByte);

  // One byte strobe, then a scrambled idle line
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rxValid <= 1'b1;
    rxByte  <= b;
    @(posedge clk);
    rxValid <= 1'b0;
    rxByte  <= ~b;
  endtask : send

  task automatic status(output logic [7:0] f, output logic [7:0] s);
    got.delete();
    send(SBSF_CMD_RSTAT);
    repeat (4) @(posedge clk);
    f = (got.size() > 0) ? got[0] : 8'hxx;
    s = (got.size() > 1) ? got[1] : 8'hxx;
  endtask : status
endmodule : sbsf_prog_model

/* serial_boot_status_flags_test.sv */
// Testbench of the status flag block: serial commands and register bus.
// Assumes the programmer model drives the receive strobe.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module serial_boot_status_flags_test
  import sbsf_pkg::*;
;
  logic clk, rstn, porN, cmdDone, dlDone, dlSumOk, idDone, idMatch;
  logic areaSel, rxValid, txValid, cmdAccept, cmdRefused;
  logic dataValid, discard;
  logic [7:0] rxByte, flashStatus, txByte, cmdCode, dataByte, f, s;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int miscompares, comparisons, cyc, nRef, nAcc, nDat, nDis;

  sbsf_top #(.TOUT_CYC(8)) dut (
    .clk, .rstn, .porN, .rxValid, .rxByte, .cmdDone, .flashStatus,
    .dlDone, .dlSumOk, .idDone, .idMatch, .areaSel, .txValid, .txByte,
    .cmdAccept, .cmdCode, .cmdRefused, .dataValid, .dataByte, .discard,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  sbsf_prog_model prog (.clk, .txValid, .txByte, .rxValid, .rxByte);

  // Clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pulse counters and hang guard
  always @(posedge clk)
  begin
    nRef += (cmdRefused === 1'b1);
    nAcc += (cmdAccept === 1'b1);
    nDat += (dataValid === 1'b1);
    nDis += (discard === 1'b1);
    cyc++;
    if (cyc == 4000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // Bus write, both halves offered together
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata  <= v;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw

  // Bus read
  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    s_axi_araddr  <= a;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr

  // One-cycle download or ID check done pulse
  task automatic done(input logic isId, input logic ok);
    @(posedge clk);
    {idDone, dlDone} <= {isId, ~isId};
    {idMatch, dlSumOk} <= {ok, ok};
    @(posedge clk);
    {idDone, dlDone} <= 2'h0;
  endtask : done

  // Verdict and end of run
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial
  begin
    {rstn, porN, cmdDone, dlDone, dlSumOk, idDone, idMatch} = 7'h0;
    {areaSel, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    flashStatus = 8'h80;
    repeat (6) @(posedge clk);
    {rstn, porN} <= 2'h3;
    axr(SBSF_OFF_STAT);
    `CHK("sec at power-on", 8'h00, d[7:0])
    areaSel <= 1'b1;
    prog.status(f, s);
    `CHK("flash status", 8'h80, f)
    `CHK("sec area", 8'h01, s)
    prog.send(8'h40);
    repeat (3) @(posedge clk);
    `CHK("refused", 1, nRef)
    `CHK("accepted", 0, nAcc)
    // Mismatch first, then a passed ID check
    for (int i = 0; i < 2; i++)
    begin
      done(1'b1, i[0]);
      prog.status(f, s);
      `CHK("sec id", {4'h0, i[0], 3'h5}, s)
    end
    prog.send(8'h40);
    repeat (2) @(posedge clk);
    `CHK("accepted", 1, nAcc)
    `CHK("command code", 8'h40, cmdCode)
    prog.send(8'h11);
    repeat (5) @(posedge clk);
    `CHK("payload bytes", 1, nDat)
    `CHK("no early discard", 0, nDis)
    `CHK("payload byte", 8'h11, dataByte)
    repeat (10) @(posedge clk);
    `CHK("discard", 1, nDis)
    prog.status(f, s);
    `CHK("sec timeout", 8'h0f, s)
    // Command end returns the handler to command wait
    prog.send(8'h40);
    cmdDone <= 1'b1;
    @(posedge clk);
    cmdDone <= 1'b0;
    prog.send(8'h22);
    repeat (2) @(posedge clk);
    `CHK("accepted after end", 3, nAcc)
    `CHK("new command code", 8'h22, cmdCode)
    `CHK("no payload after end", 1, nDat)
    cmdDone <= 1'b1;
    @(posedge clk);
    cmdDone <= 1'b0;
    done(1'b0, 1'b1);
    axr(SBSF_OFF_STAT);
    `CHK("sec sum ok", 8'h9f, d[7:0])
    // Limit register keeps its low half only
    axw(SBSF_OFF_TOUT, 32'hffff0123);
    `CHK("limit write resp", SBSF_RESP_OK, r)
    axr(SBSF_OFF_TOUT);
    `CHK("limit readback", 32'h00000123, d)
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    axr(SBSF_OFF_STAT);
    `CHK("sec over reset", 8'h9f, d[7:0])
    axr(SBSF_OFF_TOUT);
    `CHK("limit after reset", 32'h00000008, d)
    prog.send(SBSF_CMD_CLR);
    repeat (3) @(posedge clk);
    axr(SBSF_OFF_STAT);
    `CHK("sec cleared", 8'h01, d[7:0])
    `CHK("clear not refused", 1, nRef)
    done(1'b0, 1'b0);
    axr(SBSF_OFF_STAT);
    `CHK("sec sum bad", 8'h81, d[7:0])
    // Handler disabled: command bytes ignored
    axw(SBSF_OFF_CTRL, 32'h0);
    axr(SBSF_OFF_CTRL);
    `CHK("enable off", 32'h0, d)
    prog.send(8'h40);
    repeat (2) @(posedge clk);
    `CHK("ignored accept", 3, nAcc)
    `CHK("ignored refuse", 1, nRef)
    axw(SBSF_OFF_CTRL, 32'h3);
    `CHK("write resp", SBSF_RESP_OK, r)
    axr(SBSF_OFF_STAT);
    `CHK("sec bus clear", 8'h01, d[7:0])
    axr(4'hc);
    `CHK("unmapped read", SBSF_RESP_ERR, r)
    axw(4'hc, 32'h0);
    `CHK("unmapped write", SBSF_RESP_ERR, r)
    report_and_stop();
  end
endmodule : serial_boot_status_flags_test
